// ==== core/spi_dp_pkg.sv ====
// constants, register layout and carrier types of the spi status/data path
// assumes an apb slave with 32-bit data, one aligned word per register
package spi_dp_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] stat_addr = 8'h04;
    localparam logic [7:0] data_addr = 8'h08;

    // -----------------------------------------------------------------
    // spi_control bits
    // -----------------------------------------------------------------
    localparam int ctrl_rx_irq_en_bit = 7;
    localparam int ctrl_master_bit = 5;
    localparam int ctrl_cpol_bit = 4;
    localparam int ctrl_cpha_bit = 3;
    localparam int ctrl_enable_bit = 1;
    localparam int ctrl_tx_irq_en_bit = 0;
    localparam logic [7:0] ctrl_reset = 8'h28;
    localparam logic [7:0] ctrl_wmask = 8'hBB;

    // -----------------------------------------------------------------
    // spi_status_control bits
    // -----------------------------------------------------------------
    localparam int stat_rx_full_bit = 7;
    localparam int stat_err_irq_en_bit = 6;
    localparam int stat_overflow_bit = 5;
    localparam int stat_fault_bit = 4;
    localparam int stat_tx_empty_bit = 3;
    localparam int stat_fault_en_bit = 2;
    localparam int stat_rate_hi_bit = 1;
    localparam int stat_rate_lo_bit = 0;

    // -----------------------------------------------------------------
    // counts
    // -----------------------------------------------------------------
    localparam int byte_bits = 8;
    localparam int div_w = 8;

    typedef enum logic [1:0] {
        rate_div2,
        rate_div8,
        rate_div32,
        rate_div128
    } rate_sel_t;

    typedef struct packed {
        logic enable;
        logic master;
        logic cpol;
        logic cpha;
        logic fault_detect_en;
        rate_sel_t rate;
    } spi_cfg_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } spi_pins_out_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spi_pins_in_t;

    // half-period of the serial clock in mclk cycles: rate_divisor
    function automatic logic [div_w-1:0] rate_divisor(input rate_sel_t r);
        case (r)
            rate_div2: rate_divisor = 8'h02;
            rate_div8: rate_divisor = 8'h08;
            rate_div32: rate_divisor = 8'h20;
            default: rate_divisor = 8'h80;
        endcase
    endfunction : rate_divisor

endpackage : spi_dp_pkg

// ==== core/spi_pin_sync.sv ====
// three-stage synchroniser for the spi input pins
// assumes asynchronous pins; a change counts once stages two and three agree
`timescale 1ns/1ps
module spi_pin_sync
(
    input wire logic mclk,
    input wire logic srst,
    input wire spi_dp_pkg::spi_pins_in_t pins_raw,
    output spi_dp_pkg::spi_pins_in_t pins_sync
);
    import spi_dp_pkg::*;

    typedef struct packed {
        spi_pins_in_t s1;
        spi_pins_in_t s2;
        spi_pins_in_t s3;
        spi_pins_in_t q;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = pins_raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // only an agreed level moves the output, so a glitch is filtered
        for (int i = 0; i < 4; i++)
        begin
            if (st_ff.s2[i] == st_ff.s3[i])
            begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            // idle levels: clock low, select high, so no false edge follows reset
            st_ff <= '{s1: 4'h1, s2: 4'h1, s3: 4'h1, q: 4'h1};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pins_sync = st_ff.q;

endmodule : spi_pin_sync

// ==== core/spi_rate_gen.sv ====
// master serial clock tick generator
// assumes mclk is the base clock output; emits one tick per sck half-period
`timescale 1ns/1ps
module spi_rate_gen
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic run,
    input wire spi_dp_pkg::rate_sel_t rate,
    output logic tick
);
    import spi_dp_pkg::*;

    typedef struct packed {
        logic [div_w-1:0] cnt;
        logic tick;
    } rate_state_t;

    rate_state_t st_ff;
    rate_state_t nxt_st;

    // sck = base_clock_out / (2 * rate_divisor): one half-period per divisor count
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == rate_divisor(rate) - 8'h01)
        begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule : spi_rate_gen

// ==== core/spi_status_data_path.sv ====
// spi control, status and data path behind an apb slave
// assumes one mclk domain; spi pins are asynchronous and are synchronised here
//
// Function
// - set transmit-empty each time a byte moves to the shift register
// - interrupt when transmit-empty and its interrupt enable are both set
// - reset sets transmit-empty
// - idle block moves written byte to shifter, empty again within two cycles
// - busy slave defers shifter load until current transfer ends
// - fault flag can set only while fault detect enable is one
// - clearing fault detect enable leaves a set fault flag unchanged
// - enabled master without fault detect frees select pin, ignores its level
// - enabled master with fault detect keeps select as spi input
// - enabled slave always uses select pin as spi input
// - slave with fault detect low only suppresses the fault flag
// - rate code 00,01,10,11 selects divisor 2,8,32,128 in master mode
// - rate select ignored as slave; reset clears both bits
// - master sck equals base clock over twice the divisor
// - data register write loads transmit buffer
// - data register read returns receive buffer
// - transmit and receive buffers are separate storage
// - any data register read clears receive-full
// - status read with fault set then data write clears fault
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module spi_status_data_path
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spi_dp_pkg::spi_pins_in_t pins_in,
    output spi_dp_pkg::spi_pins_out_t pins_out,
    output logic ss_gpio_free,
    output logic irq
);
    import spi_dp_pkg::*;

    typedef enum logic [1:0] {
        st_idle,
        st_shift,
        st_done
    } xfer_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic err_irq_en;
        logic fault_en;
        rate_sel_t rate;
        logic rx_full;
        logic overflow;
        logic fault;
        logic fault_armed;
        logic tx_empty;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        xfer_t xfer;
        logic sck_lvl;
        logic half;
        logic sck_prev;
        logic ss_prev;
        logic mosi_o;
        logic miso_o;
        logic [31:0] rdata;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;
    spi_pins_in_t pins_s;
    logic tick;
    logic wr_acc;
    logic rd_acc;
    logic en;
    logic is_master;
    logic ss_used;
    logic sck_edge;
    logic lead_edge;
    logic samp_edge;

    // -----------------------------------------------------------------
    // leaves
    // -----------------------------------------------------------------
    spi_pin_sync u_sync
    (
        .mclk(mclk),
        .srst(srst),
        .pins_raw(pins_in),
        .pins_sync(pins_s)
    );

    spi_rate_gen u_rate
    (
        .mclk(mclk),
        .srst(srst),
        .run(en && is_master && st_ff.xfer == st_shift),
        .rate(st_ff.rate),
        .tick(tick)
    );

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    assign en = st_ff.ctrl[ctrl_enable_bit];
    assign is_master = st_ff.ctrl[ctrl_master_bit];
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // select pin is an spi input for slaves and for masters with fault detect
    assign ss_used = en && (!is_master || st_ff.fault_en);
    assign ss_gpio_free = !ss_used;
    // slave edges: leading edge shifts out (cpha=1), trailing samples
    assign sck_edge = pins_s.sck != st_ff.sck_prev;
    assign lead_edge = sck_edge && (pins_s.sck != st_ff.ctrl[ctrl_cpol_bit]);
    assign samp_edge = st_ff.ctrl[ctrl_cpha_bit] ? (sck_edge && !lead_edge) : lead_edge;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.sck_prev = pins_s.sck;
        nxt_st.ss_prev = pins_s.ss_n;

        // -------------------------------------------------------------
        // register writes
        // -------------------------------------------------------------
        if (wr_acc && paddr == ctrl_addr)
        begin
            nxt_st.ctrl = pwdata[7:0] & ctrl_wmask;
        end
        if (wr_acc && paddr == stat_addr)
        begin
            nxt_st.err_irq_en = pwdata[stat_err_irq_en_bit];
            // fault flag is not touched by this write
            nxt_st.fault_en = pwdata[stat_fault_en_bit];
            nxt_st.rate = rate_sel_t'(pwdata[stat_rate_hi_bit:stat_rate_lo_bit]);
        end
        if (wr_acc && paddr == data_addr)
        begin
            nxt_st.tx_buf = pwdata[7:0];
            nxt_st.tx_empty = 1'b0;
            if (st_ff.fault_armed)
            begin
                nxt_st.fault = 1'b0;
                nxt_st.fault_armed = 1'b0;
            end
        end
        if (rd_acc && paddr == stat_addr && st_ff.fault)
        begin
            nxt_st.fault_armed = 1'b1;
        end
        if (rd_acc && paddr == data_addr)
        begin
            nxt_st.rx_full = 1'b0;
            nxt_st.overflow = 1'b0;
        end

        // -------------------------------------------------------------
        // transfer engine
        // -------------------------------------------------------------
        case (st_ff.xfer)
            st_idle:
            begin
                // idle: buffered byte moves to shifter next cycle, slave too, so it
                // is in place before the first select or clock edge
                if (en && !st_ff.tx_empty)
                begin
                    nxt_st.shreg = st_ff.tx_buf;
                    nxt_st.tx_empty = 1'b1;
                    nxt_st.bitcnt = '0;
                    nxt_st.half = 1'b0;
                    nxt_st.sck_lvl = st_ff.ctrl[ctrl_cpol_bit];
                    nxt_st.mosi_o = st_ff.tx_buf[7];
                    nxt_st.miso_o = st_ff.tx_buf[7];
                    nxt_st.xfer = st_shift;
                end
            end
            st_shift:
            begin
                // shifter stays busy; a new write waits in tx_buf
                if (is_master && tick)
                begin
                    // divisor only acts here, in master mode
                    nxt_st.sck_lvl = !st_ff.sck_lvl;
                    nxt_st.half = !st_ff.half;
                    if (!st_ff.half)
                    begin
                        nxt_st.shreg = {st_ff.shreg[6:0], pins_s.miso};
                        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
                    end
                    else
                    begin
                        nxt_st.mosi_o = st_ff.shreg[7];
                        if (st_ff.bitcnt == 4'(byte_bits))
                        begin
                            nxt_st.xfer = st_done;
                        end
                    end
                end
                else if (!is_master)
                begin
                    if (samp_edge && !pins_s.ss_n)
                    begin
                        nxt_st.shreg = {st_ff.shreg[6:0], pins_s.mosi};
                        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
                        if (st_ff.bitcnt == 4'(byte_bits - 1))
                        begin
                            nxt_st.xfer = st_done;
                        end
                    end
                    else if (sck_edge && !samp_edge && !pins_s.ss_n)
                    begin
                        nxt_st.miso_o = st_ff.shreg[7];
                    end
                end
                if (!en)
                begin
                    nxt_st.xfer = st_idle;
                end
            end
            st_done:
            begin
                if (st_ff.rx_full)
                begin
                    nxt_st.overflow = 1'b1;
                end
                else
                begin
                    nxt_st.rx_buf = st_ff.shreg;
                    nxt_st.rx_full = 1'b1;
                end
                nxt_st.sck_lvl = st_ff.ctrl[ctrl_cpol_bit];
                nxt_st.xfer = st_idle;
            end
            default:
            begin
                nxt_st.xfer = st_idle;
            end
        endcase

        // -------------------------------------------------------------
        // mode fault; hardware set wins over the software clear
        // -------------------------------------------------------------
        if (en && st_ff.fault_en)
        begin
            if ((is_master && !pins_s.ss_n)
                || (!is_master && st_ff.xfer == st_shift && pins_s.ss_n && !st_ff.ss_prev))
            begin
                nxt_st.fault = 1'b1;
            end
        end

        // -------------------------------------------------------------
        // read data, decoded in the setup cycle and registered for the access cycle
        // -------------------------------------------------------------
        nxt_st.rdata = '0;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ctrl_addr: nxt_st.rdata = {24'h000000, st_ff.ctrl};
                stat_addr: nxt_st.rdata = {24'h000000, st_ff.rx_full, st_ff.err_irq_en,
                    st_ff.overflow, st_ff.fault, st_ff.tx_empty, st_ff.fault_en,
                    st_ff.rate};
                data_addr: nxt_st.rdata = {24'h000000, st_ff.rx_buf};
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_ff <= '0;
            st_ff.ctrl <= ctrl_reset;
            st_ff.tx_empty <= 1'b1;
            st_ff.rate <= rate_div2;
            st_ff.sck_prev <= 1'b0;
            st_ff.ss_prev <= 1'b1;
            st_ff.xfer <= st_idle;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == ctrl_addr || paddr == stat_addr
        || paddr == data_addr);
    // interrupt sources share one line; rx and error enables ride along
    assign irq = (st_ff.tx_empty && st_ff.ctrl[ctrl_tx_irq_en_bit])
        || (st_ff.rx_full && st_ff.ctrl[ctrl_rx_irq_en_bit])
        || ((st_ff.fault || st_ff.overflow) && st_ff.err_irq_en);

    always_comb
    begin
        pins_out.sck_o = st_ff.sck_lvl;
        pins_out.sck_oe = en && is_master;
        pins_out.mosi_o = st_ff.mosi_o;
        pins_out.mosi_oe = en && is_master;
        pins_out.miso_o = st_ff.miso_o;
        // slave drives miso only while selected
        pins_out.miso_oe = en && !is_master && !pins_s.ss_n;
    end

endmodule : spi_status_data_path

// ==== test/spi_dp_monitor.sv ====
// assertions on the apb port, select release, irq and serial clock of the block
// assumes it is bound to spi_status_data_path and sees only its ports
`timescale 1ns/1ps
module spi_dp_monitor
    import spi_dp_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire spi_dp_pkg::spi_pins_in_t pins_in,
    input wire spi_dp_pkg::spi_pins_out_t pins_out,
    input wire logic ss_gpio_free,
    input wire logic irq
);
    // ---------------------------------------------------------------
    // shadow of software settings, sck gap and idle counters
    // ---------------------------------------------------------------
    logic acc, mapped, tx_only, sck_chg, data_wr, sck_ff;
    logic [7:0] div, ctrl_ff, stat_ff, gap_ff, idle_ff;
    assign acc = psel && penable;
    assign mapped = paddr == ctrl_addr || paddr == stat_addr || paddr == data_addr;
    assign data_wr = acc && pwrite && paddr == data_addr;
    assign div = 8'h02 << {stat_ff[1:0], 1'b0};
    assign sck_chg = pins_out.sck_o != sck_ff;
    // only the transmit-empty source can drive irq in this setting
    assign tx_only = ctrl_ff == 8'h2B && !stat_ff[stat_err_irq_en_bit];
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_ff <= ctrl_reset;
            stat_ff <= 8'h00;
            gap_ff <= 8'hFF;
            idle_ff <= 8'hFF;
            sck_ff <= 1'b0;
        end
        else
        begin
            if (acc && pwrite && paddr == ctrl_addr)
                ctrl_ff <= pwdata[7:0] & ctrl_wmask;
            if (acc && pwrite && paddr == stat_addr)
                stat_ff <= pwdata[7:0];
            sck_ff <= pins_out.sck_o;
            gap_ff <= sck_chg ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hFF};
            idle_ff <= (sck_chg || data_wr) ? 8'h00 : idle_ff + {7'h00, idle_ff != 8'hFF};
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence idle_wr_s;
        data_wr && tx_only && idle_ff == 8'hFF;
    endsequence
    sequence refill_s;
        ##1 !irq ##[0:1] irq;
    endsequence
    apb_ready_a: assert property (acc |-> pready)
        else $error("pready low in access");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access refused");
    prdata_idle_a: assert property (!acc |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside access");
    select_use_a: assert property (ss_gpio_free == (!ctrl_ff[ctrl_enable_bit] ||
        (ctrl_ff[ctrl_master_bit] && !stat_ff[stat_fault_en_bit])))
        else $error("select pin use wrong");
    irq_quiet_a: assert property (!ctrl_ff[0] && !ctrl_ff[7] && !stat_ff[6] |-> !irq)
        else $error("irq without enable");
    tx_refill_a: assert property (idle_wr_s |-> refill_s)
        else $error("transmit empty not refilled");
    sck_half_a: assert property (ctrl_ff[5] && ctrl_ff[1] && sck_chg |->
        gap_ff >= div - 8'h01)
        else $error("sck half period short");
endmodule : spi_dp_monitor

// ==== test/spi_far_end.sv ====
// behavioural spi slave on the far side, msb first, framed by counting 8 clocks
// assumes the block is master: it samples miso on the leading sck edge and moves
// mosi on the trailing one; miso has no pull and is always driven here
`timescale 1ns/1ps
module spi_far_end
(
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic [7:0] acc = 8'h00;
    int bits = 0;
    initial rx_byte = 8'h00;
    // between frames the first bit already waits, since the master samples first
    assign miso = (bits == 0) ? tx_byte[7] : sh[7];
    always @(posedge sck)
    begin
        if (bits == 0)
            sh = tx_byte;
        acc = {acc[6:0], mosi};
        bits = (bits == 7) ? 0 : bits + 1;
        if (bits == 0)
            rx_byte = acc;
    end
    // the x to 0 step at reset lands here with bits at 0 and shifts nothing
    always @(negedge sck)
    begin
        if (bits != 0)
            sh = {sh[6:0], 1'b0};
    end
endmodule : spi_far_end

// ==== test/tb.sv ====
// self-checking bench: apb master tasks, far-end slave, one task per scenario
// assumes a 20 MHz mclk and the far end answering 8'h96 on every frame
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
    import spi_dp_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ss_gpio_free, irq, far_miso, last_err;
    logic [7:0] far_rx;
    spi_pins_in_t pins_in;
    spi_pins_out_t pins_out;
    int miscompares = 0;
    int compares = 0;
    // sck and mosi inputs only matter in slave transfers, which are not run
    assign pins_in = '{sck: 1'b0, mosi: 1'b0, miso: far_miso, ss_n: ss_n};
    spi_status_data_path u_spi_status_data_path (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
        .ss_gpio_free(ss_gpio_free), .irq(irq));
    spi_far_end u_spi_far_end (.sck(pins_out.sck_o), .mosi(pins_out.mosi_o), .tx_byte(8'h96),
        .miso(far_miso), .rx_byte(far_rx));
    initial forever #25 mclk = ~mclk;
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic poll(input int b, input logic v);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            rd(stat_addr, q);
            n++;
        end
        while (q[b] !== v && n < 1000);
        `CHECK("status flag", v, q[b])
    endtask : poll
    task automatic sck_gap(output int n);
        logic s;
        s = pins_out.sck_o;
        n = 0;
        while (pins_out.sck_o === s && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
    endtask : sck_gap
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic reset_check();
        logic [31:0] q;
        rd(ctrl_addr, q);
        `CHECK("ctrl reset", {24'h0, ctrl_reset}, q)
        rd(stat_addr, q);
        `CHECK("tx empty reset", 1'b1, q[stat_tx_empty_bit])
        `CHECK("rate reset", 2'b00, q[1:0])
        `CHECK("irq reset", 1'b0, irq)
        rd(8'h0C, q);
        `CHECK("unmapped err", 1'b1, last_err)
        `CHECK("unmapped data", 32'h0, q)
    endtask : reset_check
    task automatic tx_empty_check();
        logic [31:0] q;
        wr(stat_addr, 8'h01);
        wr(ctrl_addr, 8'h2B);
        `CHECK("irq on empty", 1'b1, irq)
        repeat (260) @(posedge mclk);
        wr(data_addr, 8'h5A);
        wr(data_addr, 8'hC3);
        rd(stat_addr, q);
        `CHECK("tx held", 1'b0, q[stat_tx_empty_bit])
        `CHECK("irq held", 1'b0, irq)
        poll(stat_tx_empty_bit, 1'b1);
        `CHECK("irq refill", 1'b1, irq)
        wr(ctrl_addr, 8'h2A);
        `CHECK("irq masked", 1'b0, irq)
        repeat (300) @(posedge mclk);
        rd(data_addr, q);
        `CHECK("rx byte", 32'h96, q)
        `CHECK("far end byte", 8'hC3, far_rx)
        rd(stat_addr, q);
        `CHECK("rx full clear", 1'b0, q[stat_rx_full_bit])
    endtask : tx_empty_check
    task automatic rate_check();
        logic [31:0] q;
        int n;
        for (int r = 0; r < 4; r++)
        begin
            wr(stat_addr, r[7:0]);
            wr(data_addr, 8'h00);
            sck_gap(n);
            sck_gap(n);
            `CHECK("half period", 2 << (2 * r), n)
            `CHECK("sck drive", 1'b1, pins_out.sck_oe)
            poll(stat_rx_full_bit, 1'b1);
            rd(data_addr, q);
            if (r == 1)
                `CHECK("rx at div8", 32'h96, q)
            repeat (260) @(posedge mclk);
        end
    endtask : rate_check
    task automatic fault_check();
        logic [31:0] q;
        wr(stat_addr, 8'h01);
        ss_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rd(stat_addr, q);
        `CHECK("fault off", 1'b0, q[stat_fault_bit])
        `CHECK("select free", 1'b1, ss_gpio_free)
        wr(stat_addr, 8'h05);
        `CHECK("select held", 1'b0, ss_gpio_free)
        repeat (10) @(posedge mclk);
        rd(stat_addr, q);
        `CHECK("fault on", 1'b1, q[stat_fault_bit])
        wr(stat_addr, 8'h01);
        ss_n <= 1'b1;
        rd(stat_addr, q);
        `CHECK("fault kept", 1'b1, q[stat_fault_bit])
        repeat (10) @(posedge mclk);
        wr(data_addr, 8'h00);
        rd(stat_addr, q);
        `CHECK("fault cleared", 1'b0, q[stat_fault_bit])
        repeat (300) @(posedge mclk);
        wr(ctrl_addr, 8'h0A);
        `CHECK("slave select", 1'b0, ss_gpio_free)
        wr(data_addr, 8'h3C);
        rd(stat_addr, q);
        `CHECK("slave load", 1'b1, q[stat_tx_empty_bit])
        ss_n <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHECK("miso drive", 1'b1, pins_out.miso_oe)
        ss_n <= 1'b1;
        repeat (10) @(posedge mclk);
        rd(stat_addr, q);
        `CHECK("slave no fault", 1'b0, q[stat_fault_bit])
    endtask : fault_check
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        reset_check();
        tx_empty_check();
        rate_check();
        fault_check();
        complete_run();
    end
    // the slowest frames take about 2100 cycles, the whole run under 12000
    initial
    begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        complete_run();
    end
endmodule : tb
bind spi_status_data_path spi_dp_monitor u_spi_dp_monitor (.mclk(mclk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .pins_out(pins_out), .ss_gpio_free(ss_gpio_free), .irq(irq));
